// ===== verification/test_time_trigger_output_unit.sv
// self-checking bench for the time trigger output unit
// assumes the pin model on the far side and a nanosecond time base
`timescale 1ns/1ns
module test_time_trigger_output_unit;
  logic        clk, rst_n, reg_wr, reg_rd, irq, act, clr, level;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, act_cnt;
  logic [31:0] sys_time;
  logic [11:0] peer_req, peer_gpio, gpio_out;
  logic [3:0]  sel;
  logic [7:0]  starts;
  int          n_mismatch, checked;
  // pulse width 3 steps, cycle 80 ns, 4 cycles or 20 pattern bits
  localparam logic [15:0] act_tab [7] = '{16'h0, 16'h0, 16'h3, 16'h3, 16'hc, 16'hc, 16'h3c};
  localparam logic [7:0]  start_tab [7] = '{8'h1, 8'h1, 8'h1, 8'h1, 8'h4, 8'h4, 8'h4};
  localparam logic [15:0] err_cfg [3] = '{16'h0112, 16'h011c, 16'h0012};
  localparam logic [15:0] err_st [3] = '{16'h0002, 16'h0002, 16'h0000};

  ttou_top #(.NUM_PINS(12)) DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_time(sys_time),
    .peer_gpio(peer_gpio), .gpio_out(gpio_out), .irq(irq));
  ttou_pin_model far_i (
    .clk(clk), .rst_n(rst_n), .gpio_out(gpio_out), .peer_req(peer_req), .sel(sel),
    .act(act), .clr(clr), .peer_gpio(peer_gpio), .act_cnt(act_cnt), .starts(starts),
    .level(level));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) sys_time <= sys_time + 32'h8;

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobes drop at the edge and the next access starts 1 ns later
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk16(reg_rdata, exp);
  endtask

  task automatic run(input logic [15:0] cfg, input int off);
    logic [31:0] t;
    t = sys_time + 32'(off);
    wr(ttou_pkg::ADDR_TARGET_LO, t[15:0]);
    wr(ttou_pkg::ADDR_TARGET_HI, t[31:16]);
    wr(ttou_pkg::ADDR_CFG_ONE, cfg);
    wr(ttou_pkg::ADDR_CONTROL, 16'h0001);
  endtask

  task automatic wait_irq(input int lim);
    int i;
    #1;
    for (i = 0; i < lim && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == lim) begin
      n_mismatch++;
      $display("BAD t=%0t irq=%h exp=%h", $time, irq, 1'b1);
      report_and_stop();
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0;
    reg_wdata = 16'h0;
    sys_time = 32'h0000_1000;
    peer_req = 12'h001;
    sel = 4'h0;
    act = 1'b0;
    clr = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 rd(ttou_pkg::ADDR_CFG_ONE, ttou_pkg::CFG_ONE_RESET);
    rd(16'h0250, 16'h0000);
    wr(ttou_pkg::ADDR_CFG_ONE, 16'hffbf);
    rd(ttou_pkg::ADDR_CFG_ONE, 16'h7f3f);
    wr(ttou_pkg::ADDR_PULSE_WIDTH, 16'h0003);
    rd(ttou_pkg::ADDR_PULSE_WIDTH, 16'h0003);
    wr(ttou_pkg::ADDR_CYC_LO, 16'h0050);
    wr(ttou_pkg::ADDR_CYC_HI, 16'h0000);
    wr(ttou_pkg::ADDR_PATTERN, 16'h000b);
    wr(ttou_pkg::ADDR_IRQ_EN, 16'h0001);
    rd(ttou_pkg::ADDR_IRQ_EN, 16'h0001);
    chk16({4'h0, gpio_out}, 16'h0001);
    // immediate fire on a past target reaches the pin four edges on
    run(16'h0312, -800);
    repeat (3) @(posedge clk);
    #1 chk16({15'h0, gpio_out[2]}, 16'h0000);
    @(posedge clk);
    #1 chk16({15'h0, gpio_out[2]}, 16'h0001);
    rd(ttou_pkg::ADDR_STATUS, 16'h0001);
    chk16({15'h0, irq}, 16'h0001);
    wr(ttou_pkg::ADDR_IRQ_EN, 16'h0000);
    @(posedge clk);
    #1 chk16({15'h0, irq}, 16'h0000);
    wr(ttou_pkg::ADDR_IRQ_EN, 16'h0001);
    wr(ttou_pkg::ADDR_STATUS, 16'h0003);
    wr(ttou_pkg::ADDR_CONTROL, 16'h0000);
    // every defined waveform code, each on its own pin down to pin 5
    for (int m = 0; m < 7; m++) begin
      wr(ttou_pkg::ADDR_COUNT, (m == 6) ? 16'h0014 : 16'h0004);
      sel <= 4'(11 - m);
      act <= m[0] || m == 6;
      run(16'h0100 | 16'(m << 4) | 16'(11 - m), 400);
      repeat (10) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      wait_irq(400);
      repeat (4) @(posedge clk);
      #1;
      if (m > 1) chk16(act_cnt, act_tab[m]);
      chk16({8'h0, starts}, {8'h0, start_tab[m]});
      chk16({15'h0, level}, {15'h0, (m < 2) ? act : !act});
      rd(ttou_pkg::ADDR_STATUS, 16'h0001);
      wr(ttou_pkg::ADDR_STATUS, 16'h0003);
      wr(ttou_pkg::ADDR_CONTROL, 16'h0000);
    end
    // late target without fire-now, unused pin, and reporting switched off
    for (int k = 0; k < 3; k++) begin
      run(err_cfg[k], (k == 1) ? 400 : -800);
      repeat (6) @(posedge clk);
      rd(ttou_pkg::ADDR_STATUS, err_st[k]);
      chk16({15'h0, irq}, 16'h0000);
      chk16({4'h0, gpio_out}, 16'h0001);
      wr(ttou_pkg::ADDR_STATUS, 16'h0003);
      wr(ttou_pkg::ADDR_CONTROL, 16'h0000);
    end
    report_and_stop();
  end
endmodule

// ===== verification/ttou_pin_model.sv
// far side of the pin bank: peer units on shared pins and a probe on one pin
// assumes sel stays put while a count runs and never points past pin 11
`timescale 1ns/1ns
module ttou_pin_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] gpio_out,
  input  wire logic [11:0] peer_req,
  input  wire logic [3:0]  sel,
  input  wire logic        act,
  input  wire logic        clr,
  output logic      [11:0] peer_gpio,
  output logic      [15:0] act_cnt,
  output logic      [7:0]  starts,
  output logic             level
);
  logic lvl_q;

  assign level = gpio_out[sel];

  // counts active cycles and entries into the active level on the probed pin
  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      act_cnt <= 16'h0;
      starts  <= 8'h0;
    end else begin
      act_cnt <= act_cnt + 16'(level == act);
      starts  <= starts + 8'((level == act) && (lvl_q != act));
    end
    lvl_q     <= level;
    peer_gpio <= rst_n ? peer_req : 12'h0;
  end
endmodule

// ===== verification/ttou_top_asserts.sv
// checker for the time trigger output unit, watching only the top ports
// assumes one clock domain and registers changed only over the plain bus
`timescale 1ns/1ns
module ttou_chk #(
  parameter int NUM_PINS = 12
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [15:0]         reg_addr,
  input wire logic [15:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [15:0]         reg_rdata,
  input wire logic [31:0]         sys_time,
  input wire logic [NUM_PINS-1:0] peer_gpio,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic                irq
);
  // ----------------------------------------------------------------
  // register shadows
  // ----------------------------------------------------------------
  logic [15:0]         cfg_sh;
  logic [15:0]         ien_sh;
  logic [15:0]         pw_sh;
  logic                en_sh;
  logic [2:0]          off_cnt;
  logic [NUM_PINS-1:0] peer_q;
  logic [NUM_PINS-1:0] own;
  logic [NUM_PINS-1:0] pin_sel;

  // peer bits are removed so only this unit's own drive is judged
  assign own     = gpio_out & ~peer_q;
  assign pin_sel = NUM_PINS'(1) << cfg_sh[3:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_sh  <= ttou_pkg::CFG_ONE_RESET;
      ien_sh  <= 16'h0;
      pw_sh   <= 16'h0;
      en_sh   <= 1'b0;
      off_cnt <= 3'h0;
      peer_q  <= '0;
    end else begin
      peer_q  <= peer_gpio;
      off_cnt <= en_sh ? 3'h0 : ((off_cnt == 3'h7) ? off_cnt : off_cnt + 3'h1);
      if (reg_wr && reg_addr == ttou_pkg::ADDR_CFG_ONE) cfg_sh <= reg_wdata & ttou_pkg::CFG_ONE_MASK;
      if (reg_wr && reg_addr == ttou_pkg::ADDR_IRQ_EN) ien_sh <= {14'h0, reg_wdata[1:0]};
      if (reg_wr && reg_addr == ttou_pkg::ADDR_PULSE_WIDTH) pw_sh <= reg_wdata;
      if (reg_wr && reg_addr == ttou_pkg::ADDR_CONTROL) en_sh <= reg_wdata[0];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  cfg_read_a: assert property (
    reg_rd && reg_addr == ttou_pkg::ADDR_CFG_ONE |=> reg_rdata == cfg_sh)
    else $error("config readback differs");
  ien_read_a: assert property (
    reg_rd && reg_addr == ttou_pkg::ADDR_IRQ_EN |=> reg_rdata == ien_sh)
    else $error("interrupt enable readback differs");
  width_read_a: assert property (
    reg_rd && reg_addr == ttou_pkg::ADDR_PULSE_WIDTH ##1 1'b1 |-> reg_rdata == pw_sh)
    else $error("pulse width readback differs");
  irq_mask_a: assert property (
    irq |-> $past(ien_sh) != 16'h0)
    else $error("interrupt raised with all sources masked");
  peer_or_a: assert property (
    (gpio_out & peer_q) == peer_q)
    else $error("peer drive lost on a pin");
  pin_route_a: assert property (
    (own & ~pin_sel) == '0)
    else $error("unit drives a pin it did not select");
  quiet_off_a: assert property (
    off_cnt >= 3'h4 |-> own == '0)
    else $error("disabled unit still drives");
  rise_hold_a: assert property (
    en_sh && cfg_sh[6:4] == 3'h1 && (|own) |=> (|own) || !en_sh)
    else $error("rising edge level not held");
  fall_hold_a: assert property (
    en_sh && cfg_sh[6:4] == 3'h0 && $fell(|own) |=> (own == '0) [*3])
    else $error("falling edge level not held");
endmodule

bind ttou_top ttou_chk #(.NUM_PINS(NUM_PINS)) chk_i (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_time(sys_time),
  .peer_gpio(peer_gpio), .gpio_out(gpio_out), .irq(irq));

// ===== verilog/ttou_pkg.sv
// constants shared by the time trigger output unit and its waveform engine
// assumes a 125 MHz clock and a nanosecond system time from the same domain
//
// Summary of operation
// - trigger-now bit 9 fires at once on a past target, else a past target is an error
// - notify bit 8 gates done/error status and their interrupt
// - pattern field 6:4 picks waveform, run only when enabled and time reached
// - code 000 falls high to low and stays, 001 rises and stays
// - code 010 gives one low pulse, 011 one high pulse, width from pulse register
// - codes 100/101 periodic, pulse and cycle widths, count zero is endless
// - code 110 shifts 16-bit pattern lsb first, looped, bit count zero endless
// - pin field 3:0 selects pin 0 to 11, values 0xc-0xf unused
// - units selecting the same pin are ORed onto it
// - pulse width counts in 8 ns steps
// - cycle or bit width counts in 1 ns steps
package ttou_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses of 16-bit registers
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CFG_ONE     = 16'h0228;
  localparam logic [15:0] ADDR_PULSE_WIDTH = 16'h022a;
  localparam logic [15:0] ADDR_CYC_LO      = 16'h022c;
  localparam logic [15:0] ADDR_CYC_HI      = 16'h022e;
  localparam logic [15:0] ADDR_COUNT       = 16'h0230;
  localparam logic [15:0] ADDR_PATTERN     = 16'h0232;
  localparam logic [15:0] ADDR_TARGET_LO   = 16'h0240;
  localparam logic [15:0] ADDR_TARGET_HI   = 16'h0242;
  localparam logic [15:0] ADDR_STATUS      = 16'h0244;
  localparam logic [15:0] ADDR_IRQ_EN      = 16'h0246;
  localparam logic [15:0] ADDR_CONTROL     = 16'h0248;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int          BIT_TRIG_NOW  = 9;
  localparam int          BIT_NOTIFY    = 8;
  localparam int          MODE_LSB      = 4;
  localparam int          PIN_LSB       = 0;
  localparam logic [15:0] CFG_ONE_MASK  = 16'h7f7f;
  localparam logic [15:0] CFG_ONE_RESET = 16'h3c00;
  localparam int          BIT_DONE      = 0;
  localparam int          BIT_ERR       = 1;
  localparam int          BIT_ENABLE    = 0;
  localparam logic [3:0]  PIN_LAST      = 4'hb;

  typedef enum logic [2:0] {
    falling_edge_mode  = 3'h0,
    rising_edge_mode   = 3'h1,
    low_pulse_mode     = 3'h2,
    high_pulse_mode    = 3'h3,
    low_periodic_mode  = 3'h4,
    high_periodic_mode = 3'h5,
    pattern_shift_mode = 3'h6,
    reserved_mode      = 3'h7
  } ttou_mode_e;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 8;
  localparam int PULSE_UNIT_NS     = 8;
  localparam int PULSE_UNIT_CYCLES = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [32:0] NS_PER_CLK = 33'(CLK_PERIOD_NS);

endpackage

// ===== verilog/ttou_top.sv
// time trigger output unit: registers, trigger timing, status and pin routing
// assumes sys_time and peer_gpio come from logic on the same clock
`timescale 1ns/1ns
module ttou_top #(
  parameter int NUM_PINS = 12
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [15:0]         reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [15:0]         reg_rdata,
  input  wire logic [31:0]         sys_time,
  input  wire logic [NUM_PINS-1:0] peer_gpio,
  output logic      [NUM_PINS-1:0] gpio_out,
  output logic                     irq
);

  if (NUM_PINS < 1 || NUM_PINS > 16) begin : g_chk
    $error("ttou_top: NUM_PINS must be 1 to 16");
  end

  typedef enum logic [1:0] {T_OFF, T_CHECK, T_WAIT, T_RUN} ttou_tst_e;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] cfg_one, next_cfg_one;
  logic [15:0] pulse_width, next_pulse_width;
  logic [15:0] cyc_lo, next_cyc_lo;
  logic [15:0] cyc_hi, next_cyc_hi;
  logic [15:0] count_reg, next_count_reg;
  logic [15:0] pattern_reg, next_pattern_reg;
  logic [15:0] target_lo, next_target_lo;
  logic [15:0] target_hi, next_target_hi;
  logic [1:0]  status, next_status;
  logic [1:0]  irq_en, next_irq_en;
  logic        unit_enable_bit, next_unit_enable_bit;
  logic [15:0] next_rdata;

  ttou_tst_e   tst, next_tst;
  logic        start, next_start;
  logic        ev_done, ev_err;
  logic [31:0] target;
  logic        notify;
  logic [3:0]  pin_sel;
  logic        pin_ok;
  logic        bad_cfg;

  ttou_wave_if wif ();

  ttou_wave u_wave (
    .clk   (clk),
    .rst_n (rst_n),
    .w     (wif)
  );

  assign target  = {target_hi, target_lo};
  assign notify  = cfg_one[ttou_pkg::BIT_NOTIFY];
  assign pin_sel = cfg_one[ttou_pkg::PIN_LSB +: 4];
  assign pin_ok  = (pin_sel <= ttou_pkg::PIN_LAST) && (32'(pin_sel) < NUM_PINS);
  // reserved waveform code or unused pin cannot be served
  assign bad_cfg = (wif.mode == ttou_pkg::reserved_mode) || !pin_ok;

  assign wif.start   = start;
  assign wif.abort   = !unit_enable_bit;
  assign wif.mode    = ttou_pkg::ttou_mode_e'(cfg_one[ttou_pkg::MODE_LSB +: 3]);
  assign wif.pulse_w = pulse_width;
  assign wif.cycle_w = {cyc_hi, cyc_lo};
  assign wif.count   = count_reg;
  assign wif.pattern = pattern_reg;

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always_comb begin
    next_cfg_one         = cfg_one;
    next_pulse_width     = pulse_width;
    next_cyc_lo          = cyc_lo;
    next_cyc_hi          = cyc_hi;
    next_count_reg       = count_reg;
    next_pattern_reg     = pattern_reg;
    next_target_lo       = target_lo;
    next_target_hi       = target_hi;
    next_irq_en          = irq_en;
    next_unit_enable_bit = unit_enable_bit;
    next_status          = status;
    next_rdata           = 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        ttou_pkg::ADDR_CFG_ONE:     next_cfg_one = reg_wdata & ttou_pkg::CFG_ONE_MASK;
        ttou_pkg::ADDR_PULSE_WIDTH: next_pulse_width = reg_wdata;
        ttou_pkg::ADDR_CYC_LO:      next_cyc_lo = reg_wdata;
        ttou_pkg::ADDR_CYC_HI:      next_cyc_hi = reg_wdata;
        ttou_pkg::ADDR_COUNT:       next_count_reg = reg_wdata;
        ttou_pkg::ADDR_PATTERN:     next_pattern_reg = reg_wdata;
        ttou_pkg::ADDR_TARGET_LO:   next_target_lo = reg_wdata;
        ttou_pkg::ADDR_TARGET_HI:   next_target_hi = reg_wdata;
        ttou_pkg::ADDR_STATUS:      next_status = status & ~reg_wdata[1:0];
        ttou_pkg::ADDR_IRQ_EN:      next_irq_en = reg_wdata[1:0];
        ttou_pkg::ADDR_CONTROL:     next_unit_enable_bit = reg_wdata[ttou_pkg::BIT_ENABLE];
        default: ;
      endcase
    end
    // hardware set wins over a clear in the same cycle
    if (notify) begin
      next_status[ttou_pkg::BIT_DONE] = next_status[ttou_pkg::BIT_DONE] | ev_done;
      next_status[ttou_pkg::BIT_ERR]  = next_status[ttou_pkg::BIT_ERR] | ev_err;
    end
    if (reg_rd) begin
      case (reg_addr)
        ttou_pkg::ADDR_CFG_ONE:     next_rdata = cfg_one;
        ttou_pkg::ADDR_PULSE_WIDTH: next_rdata = pulse_width;
        ttou_pkg::ADDR_CYC_LO:      next_rdata = cyc_lo;
        ttou_pkg::ADDR_CYC_HI:      next_rdata = cyc_hi;
        ttou_pkg::ADDR_COUNT:       next_rdata = count_reg;
        ttou_pkg::ADDR_PATTERN:     next_rdata = pattern_reg;
        ttou_pkg::ADDR_TARGET_LO:   next_rdata = target_lo;
        ttou_pkg::ADDR_TARGET_HI:   next_rdata = target_hi;
        ttou_pkg::ADDR_STATUS:      next_rdata = {14'h0000, status};
        ttou_pkg::ADDR_IRQ_EN:      next_rdata = {14'h0000, irq_en};
        ttou_pkg::ADDR_CONTROL:     next_rdata = {15'h0000, unit_enable_bit};
        default:                    next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_one         <= ttou_pkg::CFG_ONE_RESET;
      pulse_width     <= 16'h0000;
      cyc_lo          <= 16'h0000;
      cyc_hi          <= 16'h0000;
      count_reg       <= 16'h0000;
      pattern_reg     <= 16'h0000;
      target_lo       <= 16'h0000;
      target_hi       <= 16'h0000;
      status          <= 2'h0;
      irq_en          <= 2'h0;
      unit_enable_bit <= 1'b0;
      reg_rdata       <= 16'h0000;
    end else begin
      cfg_one         <= next_cfg_one;
      pulse_width     <= next_pulse_width;
      cyc_lo          <= next_cyc_lo;
      cyc_hi          <= next_cyc_hi;
      count_reg       <= next_count_reg;
      pattern_reg     <= next_pattern_reg;
      target_lo       <= next_target_lo;
      target_hi       <= next_target_hi;
      status          <= next_status;
      irq_en          <= next_irq_en;
      unit_enable_bit <= next_unit_enable_bit;
      reg_rdata       <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // trigger timing
  // ----------------------------------------------------------------
  // the past-target check is taken once, right after enabling, so a target
  // that merely becomes due later is never mistaken for a missed one
  always_comb begin
    next_tst   = tst;
    next_start = 1'b0;
    ev_done    = 1'b0;
    ev_err     = 1'b0;
    if (!unit_enable_bit) begin
      next_tst = T_OFF;
    end else begin
      case (tst)
        T_OFF: next_tst = T_CHECK;
        T_CHECK: begin
          if (bad_cfg) begin
            ev_err   = 1'b1;
            next_tst = T_RUN;
          end else if (target < sys_time) begin
            if (cfg_one[ttou_pkg::BIT_TRIG_NOW]) begin
              next_start = 1'b1;
              next_tst   = T_RUN;
            end else begin
              ev_err   = 1'b1;
              next_tst = T_RUN;
            end
          end else begin
            next_tst = T_WAIT;
          end
        end
        T_WAIT: begin
          if (sys_time >= target) begin
            next_start = 1'b1;
            next_tst   = T_RUN;
          end
        end
        T_RUN: ev_done = wif.done;
        default: next_tst = T_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tst   <= T_OFF;
      start <= 1'b0;
    end else begin
      tst   <= next_tst;
      start <= next_start;
    end
  end

  // ----------------------------------------------------------------
  // pin routing and interrupt
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] next_gpio;
  logic                next_irq;

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    // a disabled unit contributes nothing to its pin
    assign next_gpio[p] = peer_gpio[p] | (unit_enable_bit && pin_ok &&
                          pin_sel == 4'(p) && wif.level);
  end

  assign next_irq = |(status & irq_en);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpio_out <= '0;
      irq      <= 1'b0;
    end else begin
      gpio_out <= next_gpio;
      irq      <= next_irq;
    end
  end

endmodule

// ===== verilog/ttou_wave.sv
// waveform engine: edge, pulse, periodic and pattern shift generation
// assumes settings stay stable while a waveform runs
`timescale 1ns/1ns
module ttou_wave (
  input  wire logic clk,
  input  wire logic rst_n,
  ttou_wave_if.eng  w
);

  typedef enum logic [1:0] {W_IDLE, W_RUN, W_HOLD} ttou_wst_e;

  ttou_wst_e   st, next_st;
  logic        level, next_level;
  logic        done, next_done;
  logic [15:0] pw_cnt, next_pw_cnt;
  logic [32:0] ns_acc, next_ns_acc;
  logic [15:0] iter, next_iter;
  logic [3:0]  bit_idx, next_bit_idx;

  logic        act;
  logic [32:0] pw_ns;
  logic        span_end;
  logic        last_iter;

  assign act       = w.mode[0];
  // pulse width in ns for comparison against the ns accumulator
  assign pw_ns     = {14'h0000, w.pulse_w, 3'h0};
  // a span closes once the time already spent in it reaches the width,
  // so an 80 ns width lasts ten clocks rather than nine
  assign span_end  = ns_acc >= {1'b0, w.cycle_w};
  assign last_iter = (w.count != 16'h0000) && (iter + 16'h0001 == w.count);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_level   = level;
    next_done    = 1'b0;
    next_pw_cnt  = pw_cnt;
    next_ns_acc  = ns_acc;
    next_iter    = iter;
    next_bit_idx = bit_idx;
    if (w.abort) begin
      next_st    = W_IDLE;
      next_level = 1'b0;
    end else begin
      case (st)
        W_IDLE: begin
          if (w.start) begin
            next_pw_cnt  = 16'h0001;
            next_ns_acc  = ttou_pkg::NS_PER_CLK;
            next_iter    = 16'h0000;
            next_bit_idx = 4'h0;
            next_st      = W_RUN;
            case (w.mode)
              ttou_pkg::falling_edge_mode, ttou_pkg::rising_edge_mode: begin
                next_level = act;
                next_done  = 1'b1;
                next_st    = W_HOLD;
              end
              ttou_pkg::pattern_shift_mode: next_level = w.pattern[0];
              default: next_level = act;
            endcase
          end else begin
            // idle level: low modes rest high, high modes and pattern rest low
            next_level = ~w.mode[0] & ~w.mode[2] | ~w.mode[0] & ~w.mode[1];
          end
        end
        W_RUN: begin
          case (w.mode)
            ttou_pkg::low_pulse_mode, ttou_pkg::high_pulse_mode: begin
              // one pulse-register unit is one clock
              if (pw_cnt >= w.pulse_w) begin
                next_level = ~act;
                next_done  = 1'b1;
                next_st    = W_HOLD;
              end else begin
                next_pw_cnt = pw_cnt + 16'h0001;
              end
            end
            ttou_pkg::low_periodic_mode, ttou_pkg::high_periodic_mode: begin
              if (span_end) begin
                next_ns_acc = ttou_pkg::NS_PER_CLK;
                next_iter   = iter + 16'h0001;
                next_level  = last_iter ? ~act : act;
                if (last_iter) begin
                  next_done = 1'b1;
                  next_st   = W_HOLD;
                end
              end else begin
                next_ns_acc = ns_acc + ttou_pkg::NS_PER_CLK;
                next_level  = (ns_acc < pw_ns) ? act : ~act;
              end
            end
            ttou_pkg::pattern_shift_mode: begin
              if (span_end) begin
                next_ns_acc  = ttou_pkg::NS_PER_CLK;
                next_iter    = iter + 16'h0001;
                next_bit_idx = bit_idx + 4'h1;
                next_level   = last_iter ? 1'b0 : w.pattern[bit_idx + 4'h1];
                if (last_iter) begin
                  next_done = 1'b1;
                  next_st   = W_HOLD;
                end
              end else begin
                next_ns_acc = ns_acc + ttou_pkg::NS_PER_CLK;
              end
            end
            default: begin
              next_st = W_HOLD;
            end
          endcase
        end
        W_HOLD: begin
          next_st = W_HOLD;
        end
        default: begin
          next_st = W_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st      <= W_IDLE;
      level   <= 1'b0;
      done    <= 1'b0;
      pw_cnt  <= 16'h0000;
      ns_acc  <= 33'h000000000;
      iter    <= 16'h0000;
      bit_idx <= 4'h0;
    end else begin
      st      <= next_st;
      level   <= next_level;
      done    <= next_done;
      pw_cnt  <= next_pw_cnt;
      ns_acc  <= next_ns_acc;
      iter    <= next_iter;
      bit_idx <= next_bit_idx;
    end
  end

  assign w.level = level;
  assign w.done  = done;

endmodule

// ===== verilog/ttou_wave_if.sv
// signals between the unit's control logic and its waveform engine
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface ttou_wave_if;
  logic              start;
  logic              abort;
  ttou_pkg::ttou_mode_e mode;
  logic [15:0]       pulse_w;
  logic [31:0]       cycle_w;
  logic [15:0]       count;
  logic [15:0]       pattern;
  logic              level;
  logic              done;

  modport ctrl (output start, abort, mode, pulse_w, cycle_w, count, pattern,
                input level, done);
  modport eng  (input start, abort, mode, pulse_w, cycle_w, count, pattern,
                output level, done);
endinterface
